// ### rtl/timing_cfg_defs.vh
// Constants for the master configuration register bank.
// Assumes inclusion by bare name from the design files.
`ifndef TIMING_CFG_DEFS_VH
`define TIMING_CFG_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFF_RESET_STATE   7'h32
`define OFF_OSC_HOLDOVER  7'h34
`define OFF_SYNTH_FAMILY  7'h38
`define OFF_SYNTH_FREQ    7'h39
`define OFF_DIFF_FORMAT   7'h3a
`define OFF_LOOP_OPTIONS  7'h3b

// ----------------------------------------------------------------------
// Reset values (strap-loaded bits are overlaid separately)
// ----------------------------------------------------------------------
`define RST_RESET_STATE   8'h20
`define RST_OSC_HOLDOVER  8'hc2
`define RST_SYNTH_FAMILY  8'h1f
`define RST_SYNTH_FREQ    8'h08
`define RST_DIFF_FORMAT   8'h02
`define RST_LOOP_OPTIONS  8'hfb

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_SOFT_RESET    7
`define BIT_FREQ_RANGE    5
`define BIT_LOCK_PIN      4
`define BIT_OSC_EDGE      5
`define BIT_FREERUN_HO    4
`define BIT_SONET_SDH     2
`define BIT_B_ALT         7
`define BIT_B_FAMILY      6
`define BIT_A_FAMILY      5
`define BIT_AUTO_BW       7
`define BIT_INT_LIMIT     3

// ----------------------------------------------------------------------
// Forced state codes
// ----------------------------------------------------------------------
`define ST_AUTO           3'h0
`define ST_FREERUN        3'h1
`define ST_HOLDOVER       3'h2
`define ST_UNUSED         3'h3
`define ST_LOCKED         3'h4
`define ST_PRELOCKED2     3'h5
`define ST_PRELOCKED      3'h6
`define ST_LOSS_OF_LOCK   3'h7

// ----------------------------------------------------------------------
// Synthesizer frequency codes (kHz, 0 = undefined)
// ----------------------------------------------------------------------
`define KHZ_1544          16'h0608
`define KHZ_2048          16'h0800
`define KHZ_6312          16'h18a8
`define KHZ_10000         16'h2710
`define KHZ_19440         16'h4bf0
`define KHZ_38880         16'h97e0

// ----------------------------------------------------------------------
// Output format codes
// ----------------------------------------------------------------------
`define FMT_OFF           2'h0
`define FMT_LVPECL        2'h1

`endif

// ### rtl/synth_freq_decode.v
// Decodes one synthesizer's family, alternate and multiplier bits.
// Assumes the settings come straight from the register bank.
`timescale 1ns/100ps
`default_nettype none
`include "timing_cfg_defs.vh"

module synth_freq_decode #(
  parameter ALT_CAPABLE = 1
) (
  input  wire        family,
  input  wire        altFreq,
  input  wire [1:0]  multiplier,
  output reg  [15:0] freqKhz,
  output reg         freqValid
);

  always @* begin
    freqKhz   = 16'h0000;
    freqValid = 1'b1;
    if (ALT_CAPABLE != 0 && altFreq) begin
      case ({family, multiplier})
        3'b100:  freqKhz = `KHZ_19440;
        3'b101:  freqKhz = `KHZ_38880;
        3'b000:  freqKhz = `KHZ_6312;
        3'b010:  freqKhz = `KHZ_10000;
        default: freqValid = 1'b0;
      endcase
    end else if (family) begin
      freqKhz = `KHZ_1544 << multiplier;
    end else begin
      freqKhz = `KHZ_2048 << multiplier;
    end
  end

endmodule // synth_freq_decode
`default_nettype wire

// ### rtl/forced_state_decode.v
// Decodes the forced DPLL state field into one-hot controls.
// Assumes the field is held in the register bank.
`timescale 1ns/100ps
`default_nettype none
`include "timing_cfg_defs.vh"

module forced_state_decode (
  input  wire [2:0] stateField,
  output reg        forceActive,
  output reg        forceFreerun,
  output reg        forceHoldover,
  output reg        forceLocked,
  output reg        forcePrelocked2,
  output reg        forcePrelocked,
  output reg        forceLossOfLock
);

  always @* begin
    forceActive     = (stateField != `ST_AUTO);
    forceFreerun    = 1'b0;
    forceHoldover   = 1'b0;
    forceLocked     = 1'b0;
    forcePrelocked2 = 1'b0;
    forcePrelocked  = 1'b0;
    forceLossOfLock = 1'b0;
    case (stateField)
      `ST_FREERUN:      forceFreerun    = 1'b1;
      `ST_HOLDOVER:     forceHoldover   = 1'b1;
      `ST_LOCKED:       forceLocked     = 1'b1;
      `ST_PRELOCKED2:   forcePrelocked2 = 1'b1;
      `ST_PRELOCKED:    forcePrelocked  = 1'b1;
      `ST_LOSS_OF_LOCK: forceLossOfLock = 1'b1;
      // Unused code: stored, forceActive set but no individual forced state asserted
      default:          forceFreerun    = 1'b0;
    endcase
  end

endmodule // forced_state_decode
`default_nettype wire

// ### rtl/timing_master_config_regs.v
// Master configuration register bank of the line-card timing device.
// Assumes a synchronous byte-wide processor port on ref_clk; the DPLL,
// input monitors and output drivers sit outside and use these controls.
`timescale 1ns/100ps
`default_nettype none
`include "timing_cfg_defs.vh"

module timing_master_config_regs #(
  parameter AW = 7
) (
  input  wire          ref_clk,
  input  wire          rst_n,
  // Processor port
  input  wire [AW-1:0] regAddr,
  input  wire [7:0]    regWrData,
  input  wire          regWrEn,
  input  wire          regRdEn,
  output reg  [7:0]    regRdData,
  output wire          regHit,
  // Strap pin and DPLL status
  input  wire          sonetSdhStrap,
  input  wire [2:0]    dpllStateIn,
  input  wire          dpllAtLimit,
  input  wire          dpllAcquiring,
  // Controls out
  output wire          deviceResetHold,
  output wire          freqRangeDetectEn,
  output wire          lockPinOut,
  output wire          lockPinOe,
  output wire          forceActive,
  output wire          forceFreerun,
  output wire          forceHoldover,
  output wire          forceLocked,
  output wire          forcePrelocked2,
  output wire          forcePrelocked,
  output wire          forceLossOfLock,
  output wire          oscFallingEdge,
  output wire          holdoverZeroOffset,
  output wire [15:0]   inputCode1Khz,
  output wire [15:0]   synthAFreqKhz,
  output wire [15:0]   synthBFreqKhz,
  output wire          synthBFreqValid,
  output wire          diffOutPowerDown,
  output wire          diffOutLvpecl,
  output wire          diffOutLvds,
  output wire          useAcqBandwidth,
  output wire          freezeIntegral
);

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  reg  [7:0] resetState_q;
  reg  [7:0] oscHoldover_q;
  reg  [7:0] synthFamily_q;
  reg  [7:0] synthFreq_q;
  reg  [7:0] diffFormat_q;
  reg  [7:0] loopOptions_q;
  reg        strapLatched_q;

  wire       softReset = resetState_q[`BIT_SOFT_RESET];

  // Strap value overlaid onto the three rate-select defaults
  function [7:0] withStrap;
    input [7:0] base;
    input integer pos;
    input       strap;
    begin
      withStrap      = base;
      withStrap[pos] = strap;
    end
  endfunction

  function sel;
    input [AW-1:0] a;
    input [AW-1:0] off;
    begin
      sel = (a == off);
    end
  endfunction

  // --------------------------------------------------------------------
  // Strap capture
  // --------------------------------------------------------------------
  // Sampled while the pin reset is held, never during soft reset, so a
  // soft reset reuses the last pin-reset capture.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      strapLatched_q <= sonetSdhStrap;
    end
  end

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  localparam NREG = 6;

  // Offset of each stored register; one table feeds both the write
  // strobes and the hit flag so the two can never disagree.
  function [AW-1:0] regOffset;
    input integer idx;
    begin
      case (idx)
        0:       regOffset = `OFF_RESET_STATE;
        1:       regOffset = `OFF_OSC_HOLDOVER;
        2:       regOffset = `OFF_SYNTH_FAMILY;
        3:       regOffset = `OFF_SYNTH_FREQ;
        4:       regOffset = `OFF_DIFF_FORMAT;
        default: regOffset = `OFF_LOOP_OPTIONS;
      endcase
    end
  endfunction

  wire [NREG-1:0] addrHit;

  // One comparator per stored register
  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : gAddrHit
      assign addrHit[g] = sel(regAddr, regOffset(g));
    end
  endgenerate

  wire wrReset  = regWrEn && addrHit[0];
  wire wrOsc    = regWrEn && addrHit[1];
  wire wrFamily = regWrEn && addrHit[2];
  wire wrFreq   = regWrEn && addrHit[3];
  wire wrFormat = regWrEn && addrHit[4];
  wire wrLoop   = regWrEn && addrHit[5];

  // Reset bit itself survives soft reset so software can release it
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      resetState_q <= `RST_RESET_STATE;
    end else if (wrReset) begin
      resetState_q <= regWrData;
    end else if (softReset) begin
      resetState_q <= `RST_RESET_STATE | 8'h80;
    end
  end

  // Strap-loaded fields: pin reset takes the live pin value through the
  // latch path one cycle later; reset values use the held capture.
  wire [7:0] oscDefault = withStrap(`RST_OSC_HOLDOVER, `BIT_SONET_SDH,
                                    strapLatched_q);
  wire [7:0] famDefault = withStrap(withStrap(`RST_SYNTH_FAMILY,
                                    `BIT_B_FAMILY, strapLatched_q),
                                    `BIT_A_FAMILY, strapLatched_q);

  // Registers still held at defaults while rst_n is low; strap bits are
  // rewritten the first cycle after release from the captured value.
  reg rstDone_q;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      rstDone_q <= 1'b0;
    end else begin
      rstDone_q <= 1'b1;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      oscHoldover_q <= `RST_OSC_HOLDOVER;
      synthFamily_q <= `RST_SYNTH_FAMILY;
      synthFreq_q   <= `RST_SYNTH_FREQ;
      diffFormat_q  <= `RST_DIFF_FORMAT;
      loopOptions_q <= `RST_LOOP_OPTIONS;
    end else if (softReset || !rstDone_q) begin
      oscHoldover_q <= oscDefault;
      synthFamily_q <= famDefault;
      synthFreq_q   <= `RST_SYNTH_FREQ;
      diffFormat_q  <= `RST_DIFF_FORMAT;
      loopOptions_q <= `RST_LOOP_OPTIONS;
    end else begin
      if (wrOsc) begin
        oscHoldover_q <= regWrData;
      end
      if (wrFamily) begin
        synthFamily_q <= regWrData;
      end
      if (wrFreq) begin
        synthFreq_q <= regWrData;
      end
      if (wrFormat) begin
        diffFormat_q <= regWrData;
      end
      if (wrLoop) begin
        loopOptions_q <= regWrData;
      end
    end
  end

  // --------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------
  assign regHit = |addrHit;

  reg [7:0] rdMux;
  always @* begin
    case (regAddr)
      `OFF_RESET_STATE:  rdMux = resetState_q;
      `OFF_OSC_HOLDOVER: rdMux = oscHoldover_q;
      `OFF_SYNTH_FAMILY: rdMux = synthFamily_q;
      `OFF_SYNTH_FREQ:   rdMux = synthFreq_q;
      `OFF_DIFF_FORMAT:  rdMux = diffFormat_q;
      `OFF_LOOP_OPTIONS: rdMux = loopOptions_q;
      default:           rdMux = 8'h00;
    endcase
  end

  // Read data registered; unmapped offsets read zero
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      regRdData <= rdMux;
    end
  end

  // --------------------------------------------------------------------
  // Control decode
  // --------------------------------------------------------------------
  // Every downstream block treats this as its own synchronous reset
  assign deviceResetHold   = softReset;
  // Gated during soft reset so downstream logic sees idle controls
  assign freqRangeDetectEn = resetState_q[`BIT_FREQ_RANGE]
                             && !softReset;

  // Lock pin: driven only when enabled and out of reset; the
  // tri-state buffer itself sits outside this bank
  assign lockPinOe  = resetState_q[`BIT_LOCK_PIN]
                      && !softReset;
  assign lockPinOut = lockPinOe && (dpllStateIn == `ST_LOCKED);

  forced_state_decode uForced (
    .stateField      (resetState_q[2:0]),
    .forceActive     (forceActive),
    .forceFreerun    (forceFreerun),
    .forceHoldover   (forceHoldover),
    .forceLocked     (forceLocked),
    .forcePrelocked2 (forcePrelocked2),
    .forcePrelocked  (forcePrelocked),
    .forceLossOfLock (forceLossOfLock)
  );

  assign oscFallingEdge     = oscHoldover_q[`BIT_OSC_EDGE];
  assign holdoverZeroOffset = oscHoldover_q[`BIT_FREERUN_HO];
  assign inputCode1Khz      = oscHoldover_q[`BIT_SONET_SDH] ?
                              `KHZ_1544 : `KHZ_2048;

  synth_freq_decode #(
    .ALT_CAPABLE (0)
  ) uSynthA (
    .family     (synthFamily_q[`BIT_A_FAMILY]),
    .altFreq    (1'b0),
    .multiplier (synthFreq_q[5:4]),
    .freqKhz    (synthAFreqKhz),
    .freqValid  ()
  );

  synth_freq_decode #(
    .ALT_CAPABLE (1)
  ) uSynthB (
    .family     (synthFamily_q[`BIT_B_FAMILY]),
    .altFreq    (synthFamily_q[`BIT_B_ALT]),
    .multiplier (synthFreq_q[7:6]),
    .freqKhz    (synthBFreqKhz),
    .freqValid  (synthBFreqValid)
  );

  // Codes 10 and 11 both select LVDS; swing trim is software's job
  assign diffOutPowerDown = (diffFormat_q[1:0] == `FMT_OFF);
  assign diffOutLvpecl    = (diffFormat_q[1:0] == `FMT_LVPECL);
  assign diffOutLvds      = diffFormat_q[1];

  assign useAcqBandwidth = loopOptions_q[`BIT_AUTO_BW]
                           && dpllAcquiring;
  assign freezeIntegral  = loopOptions_q[`BIT_INT_LIMIT]
                           && dpllAtLimit;

endmodule // timing_master_config_regs
`default_nettype wire

// ### verification/timing_master_config_regs_asserts.sv
// Checker for the master configuration register bank.
// Sees only the top module's ports; bound in below.
`timescale 1ns/100ps
`default_nettype none
module timing_master_config_regs_asserts (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        sonetSdhStrap,
  input wire logic [2:0]  dpllStateIn,
  input wire logic        dpllAtLimit,
  input wire logic        dpllAcquiring,
  input wire logic        deviceResetHold,
  input wire logic        freqRangeDetectEn,
  input wire logic        lockPinOut,
  input wire logic        lockPinOe,
  input wire logic        oscFallingEdge,
  input wire logic [15:0] inputCode1Khz,
  input wire logic [15:0] synthAFreqKhz,
  input wire logic [15:0] synthBFreqKhz,
  input wire logic        synthBFreqValid,
  input wire logic        diffOutPowerDown,
  input wire logic        diffOutLvpecl,
  input wire logic        diffOutLvds,
  input wire logic        useAcqBandwidth,
  input wire logic        freezeIntegral
);
  // ------------
  // Strap capture
  // ------------
  // Mirrors the strap seen at the last edge of the hardware reset
  logic strapQ;
  always @(posedge ref_clk)
    if (!rst_n)
      strapQ <= sonetSdhStrap;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_lock; lockPinOut == (lockPinOe && dpllStateIn == 3'h4);
  endproperty
  a_lock: assert property (p_lock) else $error("lock pin wrong");
  property p_soft; $past(deviceResetHold) && deviceResetHold |->
    diffOutLvds && !oscFallingEdge && !freqRangeDetectEn; endproperty
  a_soft: assert property (p_soft) else $error("soft reset leak");
  property p_keep; $past(deviceResetHold) && deviceResetHold |->
    inputCode1Khz == (strapQ ? 16'h0608 : 16'h0800)
    && synthAFreqKhz == inputCode1Khz && synthBFreqKhz == inputCode1Khz;
  endproperty
  a_keep: assert property (p_keep) else $error("strap resampled");
  property p_strap;
    $rose(rst_n) |=> inputCode1Khz == (strapQ ? 16'h0608 : 16'h0800);
  endproperty
  a_strap: assert property (p_strap) else $error("strap lost");
  property p_rate; inputCode1Khz inside {16'h0608, 16'h0800}; endproperty
  a_rate: assert property (p_rate) else $error("rate wrong");
  property p_synA; synthAFreqKhz inside {16'h0608, 16'h0c10, 16'h1820,
    16'h3040, 16'h0800, 16'h1000, 16'h2000, 16'h4000}; endproperty
  a_synA: assert property (p_synA) else $error("synth a freq");
  property p_synB; synthBFreqValid == (synthBFreqKhz != 16'h0000);
  endproperty
  a_synB: assert property (p_synB) else $error("synth b valid");
  property p_fmt;
    $onehot({diffOutPowerDown, diffOutLvpecl, diffOutLvds}); endproperty
  a_fmt: assert property (p_fmt) else $error("format decode");
  property p_acq; useAcqBandwidth |-> dpllAcquiring; endproperty
  a_acq: assert property (p_acq) else $error("bandwidth");
  property p_frz; freezeIntegral |-> dpllAtLimit; endproperty
  a_frz: assert property (p_frz) else $error("freeze");
endmodule // timing_master_config_regs_asserts

bind timing_master_config_regs timing_master_config_regs_asserts u_chk (
  .ref_clk, .rst_n, .sonetSdhStrap, .dpllStateIn, .dpllAtLimit,
  .dpllAcquiring, .deviceResetHold, .freqRangeDetectEn, .lockPinOut,
  .lockPinOe, .oscFallingEdge, .inputCode1Khz, .synthAFreqKhz,
  .synthBFreqKhz, .synthBFreqValid, .diffOutPowerDown, .diffOutLvpecl,
  .diffOutLvds, .useAcqBandwidth, .freezeIntegral);
`default_nettype wire

// ### verification/timing_master_config_regs_tb.sv
// Self-checking bench for the master configuration register bank.
// Drives the processor port, strap and DPLL status itself.
`timescale 1ns/100ps
`default_nettype none
module timing_master_config_regs_tb;
  logic        ref_clk, rst_n, regWrEn, regRdEn, sonetSdhStrap, strap;
  logic        dpllAtLimit, dpllAcquiring;
  logic [6:0]  regAddr;
  logic [7:0]  regWrData, d;
  logic [2:0]  dpllStateIn;
  wire  [7:0]  regRdData;
  wire         regHit, deviceResetHold, freqRangeDetectEn, lockPinOut;
  wire         lockPinOe, forceActive, forceFreerun, forceHoldover;
  wire         forceLocked, forcePrelocked2, forcePrelocked;
  wire         forceLossOfLock, oscFallingEdge, holdoverZeroOffset;
  wire         synthBFreqValid, diffOutPowerDown, diffOutLvpecl;
  wire         diffOutLvds, useAcqBandwidth, freezeIntegral;
  wire  [15:0] inputCode1Khz, synthAFreqKhz, synthBFreqKhz;
  integer      failures, nTests, seed, i, k;
  logic [31:0] rnd;
  logic [7:0]  sh [0:6];
  logic [6:0]  offs [0:6] = '{7'h32, 7'h34, 7'h38, 7'h39, 7'h3a, 7'h3b,
                              7'h33};

  timing_master_config_regs dut (
    .ref_clk, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
    .regHit, .sonetSdhStrap, .dpllStateIn, .dpllAtLimit, .dpllAcquiring,
    .deviceResetHold, .freqRangeDetectEn, .lockPinOut, .lockPinOe,
    .forceActive, .forceFreerun, .forceHoldover, .forceLocked,
    .forcePrelocked2, .forcePrelocked, .forceLossOfLock, .oscFallingEdge,
    .holdoverZeroOffset, .inputCode1Khz, .synthAFreqKhz, .synthBFreqKhz,
    .synthBFreqValid, .diffOutPowerDown, .diffOutLvpecl, .diffOutLvds,
    .useAcqBandwidth, .freezeIntegral);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ------------
  // Expectations and port tasks
  // ------------
  function logic [15:0] fa(input logic f, input logic [1:0] m);
    fa = (f ? 16'h0608 : 16'h0800) << m;
  endfunction
  function logic [16:0] fb(input logic alt, f, input logic [1:0] m);
    if (!alt) fb = {1'b1, fa(f, m)};
    else case ({f, m})
      3'h4: fb = 17'h14bf0;
      3'h5: fb = 17'h197e0;
      3'h0: fb = 17'h118a8;
      3'h2: fb = 17'h12710;
      default: fb = 17'h00000;
    endcase
  endfunction
  function logic [5:0] fs(input logic [2:0] c);
    fs = c == 3'h1 ? 6'h20 : c == 3'h2 ? 6'h10 :
         c[2] ? 6'h08 >> c[1:0] : 6'h00;
  endfunction
  task chk(input logic [63:0] got, input logic [63:0] exp);
    nTests = nTests + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("comparisons=%0d mismatches=%0d", nTests, failures);
    if (failures == 0 && nTests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Status inputs move with every write so the decodes see fresh values
  task wr(input logic [6:0] a, input logic [7:0] v);
    logic [31:0] r;
    r = $random(seed);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= v;
    regWrEn <= 1'b1;
    dpllStateIn <= r[2:0];
    dpllAtLimit <= r[3];
    dpllAcquiring <= r[4];
    @(posedge ref_clk);
    regWrEn <= 1'b0;
  endtask
  task put(input integer j, input logic [7:0] v);
    wr(offs[j], v);
    if (j < 6) sh[j] = v;
  endtask
  task rd(input integer j);
    @(posedge ref_clk);
    regAddr <= offs[j];
    regRdEn <= 1'b1;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    #1;
    chk({regHit, regRdData}, {j < 6, sh[j]});
  endtask
  task rstvals;
    sh[0] = 8'h20;
    sh[1] = {5'h18, strap, 2'h2};
    sh[2] = {1'b0, strap, strap, 5'h1f};
    sh[3] = 8'h08;
    sh[4] = 8'h02;
    sh[5] = 8'hfb;
    sh[6] = 8'h00;
  endtask
  task dec;
    #1;
    chk({freqRangeDetectEn, lockPinOe, lockPinOut, oscFallingEdge,
      holdoverZeroOffset, inputCode1Khz, synthAFreqKhz, synthBFreqValid,
      synthBFreqKhz, diffOutPowerDown, diffOutLvpecl, diffOutLvds,
      useAcqBandwidth, freezeIntegral, deviceResetHold},
      {sh[0][5] & ~sh[0][7], sh[0][4] & ~sh[0][7],
      sh[0][4] & ~sh[0][7] & (dpllStateIn == 3'h4),
      sh[1][5], sh[1][4], sh[1][2] ? 16'h0608 : 16'h0800,
      fa(sh[2][5], sh[3][5:4]), fb(sh[2][7], sh[2][6], sh[3][7:6]),
      sh[4][1:0] == 2'h0, sh[4][1:0] == 2'h1, sh[4][1],
      sh[5][7] & dpllAcquiring, sh[5][3] & dpllAtLimit,
      sh[0][7]});
    chk({forceActive, forceFreerun, forceHoldover, forceLocked,
      forcePrelocked2, forcePrelocked, forceLossOfLock},
      {|sh[0][2:0], fs(sh[0][2:0])});
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures = failures + 1;
    print_verdict;
  end

  // ------------
  // Main sequence
  // ------------
  initial begin
    seed = 50;
    failures = 0;
    nTests = 0;
    regAddr = 7'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    dpllStateIn = 3'h0;
    dpllAtLimit = 1'b0;
    dpllAcquiring = 1'b0;
    rst_n = 1'b0;
    rnd = $random(seed);
    strap = rnd[0];
    sonetSdhStrap = strap;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Flip the strap so any resample by a soft reset shows up later
    sonetSdhStrap <= ~strap;
    repeat (2) @(posedge ref_clk);
    rstvals;
    dec;
    for (i = 0; i < 7; i = i + 1) rd(i);
    for (k = 0; k < 8; k = k + 1) begin
      put(0, {5'h06, k[2:0]});
      put(4, {6'h00, k[1:0]});
      dec;
    end
    for (k = 0; k < 16; k = k + 1) begin
      put(2, {k[3:1], 5'h1f});
      put(3, {k[1:0], k[3:2], 4'h8});
      dec;
    end
    for (k = 0; k < 150; k = k + 1) begin
      i = $unsigned($random(seed)) % 7;
      rnd = $random(seed);
      d = rnd[7:0];
      if (i == 0) d[7] = 1'b0;
      put(i, d);
      dec;
      rd(i);
    end
    // Swing trim writes land in another block; this bank must ignore
    // them and keep the format field just set
    for (k = 0; k < 2; k = k + 1) begin
      put(4, 8'h01 << k);
      wr(7'h7f, 8'h01);
      wr(7'h58, k ? 8'h00 : 8'h55);
      wr(7'h7f, 8'h00);
      dec;
      rd(4);
    end
    put(0, 8'h80);
    rstvals;
    sh[0] = 8'ha0;
    repeat (2) @(posedge ref_clk);
    dec;
    rd(0);
    wr(offs[4], 8'h01);
    rd(4);
    put(0, 8'h20);
    dec;
    for (i = 0; i < 7; i = i + 1) rd(i);
    print_verdict;
  end
endmodule // timing_master_config_regs_tb
`default_nettype wire
